// ===== alert_line_model.sv
// host-side view of the open-drain alert line with its pull-up
`timescale 1ns/100ps
`default_nettype none
module alert_line_model
(
    // device pin
    input wire logic pin_o,
    input wire logic pin_oe_n,
    // line as the host sees it
    output logic alert_line
);
    ////////////////////////////////////////////////////////////////////
    // pull-up wins whenever the device lets go of the line
    assign alert_line = pin_oe_n ? 1'b1 : pin_o;
endmodule
`default_nettype wire

// ===== alert_mask_and_thermal_timer_tb.sv
// self-checking bench for the alert and thermal timer controller
`timescale 1ns/100ps
`default_nettype none
`include "alert_thermal_cfg.svh"
module alert_mask_and_thermal_timer_tb;
    import alert_thermal_pkg::*;
    localparam int TICK = 8;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    byte_t reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    byte_t reg_wdata = 8'h00;
    byte_t reg_rdata;
    byte_t limit_fault_one = 8'h00;
    byte_t limit_fault_two = 8'h00;
    logic [2:0] fan_running = 3'b000;
    logic [2:0] full_speed_override;
    logic thermal_event_pin_n = 1'b1;
    logic alert_pin_o;
    logic alert_pin_oe_n;
    logic alert_line;
    int num_errors = 0;
    int n_tests = 0;

    ////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;

    alert_thermal_ctrl #(.TICK_CYCLES(TICK)) uut
    (
        .clk(clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .limit_fault_one(limit_fault_one),
        .limit_fault_two(limit_fault_two),
        .fan_running(fan_running),
        .full_speed_override(full_speed_override),
        .thermal_event_pin_n(thermal_event_pin_n),
        .alert_pin_i(alert_line),
        .alert_pin_o(alert_pin_o),
        .alert_pin_oe_n(alert_pin_oe_n)
    );

    alert_line_model host
    (
        .pin_o(alert_pin_o),
        .pin_oe_n(alert_pin_oe_n),
        .alert_line(alert_line)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input byte_t seen,
                         input byte_t exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input byte_t a, output byte_t d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic rdchk(input byte_t a, input byte_t e, input string n);
        byte_t d;
        rd(a, d);
        check(n, d, e);
    endtask

    task automatic alert_is(input logic e);
        check("alert_line", {7'h00, alert_line}, {7'h00, e});
    endtask

    task automatic pin_low(input int n);
        thermal_event_pin_n = 1'b0;
        idle(n);
        thermal_event_pin_n = 1'b1;
        idle(4);
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        byte_t addrs [9];
        addrs = '{8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7A,
                  8'h7D, 8'h80};
        foreach (addrs[i])
            rdchk(addrs[i], `RESET_BYTE, "reset_value");
        limit_fault_one = 8'h20;
        idle(4);
        alert_is(1'b1);
        limit_fault_one = 8'h00;
        rdchk(`ADDR_STATUS_ONE, 8'h20, "flag_with_pin_off");
        wr(`ADDR_MASK_ONE, 8'h5A);
        rdchk(`ADDR_MASK_ONE, 8'h5A, "mask_one_rw");
        wr(`ADDR_MASK_ONE, 8'h00);
        wr(`ADDR_TIMER, 8'h77);
        rdchk(`ADDR_TIMER, 8'h00, "timer_not_writable");
        done("reset");
    endtask

    task automatic t_sticky;
        wr(`ADDR_ALERT_CFG, 8'h01);
        limit_fault_one = 8'h10;
        idle(4);
        alert_is(1'b0);
        rdchk(`ADDR_STATUS_ONE, 8'h10, "read_while_fault");
        alert_is(1'b0);
        limit_fault_one = 8'h00;
        idle(3);
        alert_is(1'b0);
        rdchk(`ADDR_STATUS_ONE, 8'h10, "sticky_flag");
        idle(2);
        alert_is(1'b1);
        rdchk(`ADDR_STATUS_ONE, 8'h00, "cleared_flag");
        done("sticky");
    endtask

    task automatic t_mask_bits;
        byte_t b;
        byte_t used;
        byte_t sreg;
        byte_t mreg;
        for (int k = 0; k < 16; k++)
        begin
            b = 8'h01 << k[2:0];
            used = k[3] ? `USED_STATUS_TWO : `USED_STATUS_ONE;
            sreg = k[3] ? `ADDR_STATUS_TWO : `ADDR_STATUS_ONE;
            mreg = k[3] ? `ADDR_MASK_TWO : `ADDR_MASK_ONE;
            if ((used & b) != 8'h00)
            begin
                wr(mreg, b);
                if (k[3]) limit_fault_two = b;
                else limit_fault_one = b;
                idle(4);
                alert_is(1'b1);
                limit_fault_one = 8'h00;
                limit_fault_two = 8'h00;
                if (k[3])
                    rdchk(`ADDR_STATUS_ONE, 8'h80, "summary");
                rdchk(sreg, b, "masked_flag");
                rdchk(sreg, 8'h00, "flag_gone");
                wr(mreg, 8'h00);
                if (k[3]) limit_fault_two = b;
                else limit_fault_one = b;
                idle(4);
                alert_is(1'b0);
                limit_fault_one = 8'h00;
                limit_fault_two = 8'h00;
                rdchk(sreg, b, "unmasked_flag");
                idle(2);
                alert_is(1'b1);
            end
        end
        wr(`ADDR_MASK_ONE, 8'h80);
        limit_fault_two = 8'h08;
        idle(4);
        alert_is(1'b1);
        limit_fault_two = 8'h00;
        rdchk(`ADDR_STATUS_TWO, 8'h08, "summary_masked");
        wr(`ADDR_MASK_ONE, 8'h00);
        done("mask_bits");
    endtask

    task automatic t_timer;
        pin_low(10);
        rdchk(`ADDR_TIMER, 8'h00, "timer_disabled");
        wr(`ADDR_PIN_CFG, 8'h02);
        wr(`ADDR_TIMER_LIMIT, 8'h01);
        wr(`ADDR_MASK_TWO, 8'h20);
        pin_low(5);
        rdchk(`ADDR_STATUS_TWO, 8'h00, "limit_one_first");
        pin_low(23);
        alert_is(1'b1);
        rdchk(`ADDR_TIMER, 8'h03, "accumulated");
        rdchk(`ADDR_TIMER, 8'h00, "clear_on_read");
        rdchk(`ADDR_STATUS_TWO, 8'h20, "timer_flag");
        rdchk(`ADDR_STATUS_TWO, 8'h00, "timer_flag_gone");
        pin_low(TICK * 256 + 40);
        rdchk(`ADDR_TIMER, `TIMER_FULL, "saturated");
        rdchk(`ADDR_STATUS_TWO, 8'h20, "limit_passed");
        done("timer");
    endtask

    task automatic t_read_active;
        byte_t d;
        wr(`ADDR_TIMER_LIMIT, 8'h00);
        wr(`ADDR_MASK_TWO, 8'h00);
        rd(`ADDR_STATUS_TWO, d);
        thermal_event_pin_n = 1'b0;
        idle(5);
        alert_is(1'b0);
        rd(`ADDR_TIMER, d);
        rdchk(`ADDR_TIMER, 8'h01, "read_active");
        rdchk(`ADDR_STATUS_TWO, 8'h20, "flag_again");
        thermal_event_pin_n = 1'b1;
        idle(4);
        rd(`ADDR_TIMER, d);
        rd(`ADDR_STATUS_TWO, d);
        rdchk(`ADDR_STATUS_TWO, 8'h00, "flag_cleared");
        done("read_active");
    endtask

    task automatic t_override;
        byte_t d;
        wr(`ADDR_PIN_CFG, 8'h06);
        fan_running = 3'b101;
        thermal_event_pin_n = 1'b0;
        idle(5);
        check("override_on", {5'h00, full_speed_override},
              8'h05);
        thermal_event_pin_n = 1'b1;
        idle(5);
        check("override_off", {5'h00, full_speed_override},
              8'h00);
        fan_running = 3'b000;
        rd(`ADDR_TIMER, d);
        done("override");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        idle(2);
        nrst = 1'b1;
        idle(3);
        t_reset();
        t_sticky();
        t_mask_bits();
        t_timer();
        t_read_active();
        t_override();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire

// ===== alert_thermal_cfg.svh
// constants for the alert mask and thermal timer block
`ifndef ALERT_THERMAL_CFG_SVH
`define ALERT_THERMAL_CFG_SVH

// register offsets
`define ADDR_STATUS_ONE 8'h41
`define ADDR_STATUS_TWO 8'h42
`define ADDR_MASK_ONE 8'h74
`define ADDR_MASK_TWO 8'h75
`define ADDR_PIN_CFG 8'h78
`define ADDR_TIMER 8'h79
`define ADDR_TIMER_LIMIT 8'h7A
`define ADDR_ALERT_CFG 8'h7D

// field positions
`define BIT_SUMMARY 7
`define BIT_TIMER_FLAG 5
`define BIT_THERMAL_EVENT_PIN_SELECT 1
`define BIT_OVERRIDE_EN 2
`define BIT_ALERT_SELECT 0

// reset values and used-bit masks
`define RESET_BYTE 8'h00
`define RESET_TIMER_LIMIT 8'h00
`define USED_STATUS_ONE 8'h75
`define USED_STATUS_TWO 8'hFE
`define TIMER_FULL 8'hFF

// timer tick: 22.76 ms at 200 MHz
`define TICK_TIME_US 22760
`define CLK_FREQ_MHZ 200

`endif

// ===== alert_thermal_ctrl.sv
// alert masking, sticky status and thermal input monitoring
// Summary of operation
// - out-of-limit reading sets its flag; held until cause gone and read
// - alert held low while unmasked fault persists and until status read
// - mask bit blocks only the alert; status flag still sets
// - mask one: 7 summary, 6 remote two, 5 local, 4 remote one, 2, 0
// - mask two: 7,6 diode faults, 5..2 fans, 1 overtemperature
// - with thermal pin selected, mask two bit 5 masks timer-limit alert
// - alert pin off after reset; config four bit 0 enables it
// - config three bit 1 selects thermal pin and enables monitoring
// - config three bit 2 forces full fan drive while input is low
// - override applies only to fans already running
// - timer counts while asserted, pauses when negated, accumulates
// - timer cleared on read; saturates at full scale until cleared
// - bit 0 on first assertion; from 45.52 ms counts 22.76 ms steps
// - read during assertion clears, sets bit 0, restarts counting
// - read during assertion with limit zero sets timer flag again
// - timer above limit sets status two bit 5 and alert
// - limit spans first assertion up to 5.8038 s
// - limit zero alerts on first assertion, one after 45.52 ms
// - status read clears flags whose cause has gone
// - status one bit 7 reads 1 when any status two flag set
// - with thermal timer used, status two bit 5 is timer flag
`timescale 1ns/100ps
`default_nettype none
`include "alert_thermal_cfg.svh"
module alert_thermal_ctrl
#(
    parameter int TICK_CYCLES = `TICK_TIME_US * `CLK_FREQ_MHZ
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire alert_thermal_pkg::byte_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire alert_thermal_pkg::byte_t reg_wdata,
    output alert_thermal_pkg::byte_t reg_rdata,
    // out-of-limit causes, status one layout
    input wire alert_thermal_pkg::byte_t limit_fault_one,
    // out-of-limit causes, status two layout
    input wire alert_thermal_pkg::byte_t limit_fault_two,
    // fan state
    input wire logic [2:0] fan_running,
    output logic [2:0] full_speed_override,
    // thermal event pin, active low
    input wire logic thermal_event_pin_n,
    // alert pin, open drain
    input wire logic alert_pin_i,
    output logic alert_pin_o,
    output logic alert_pin_oe_n
);
    import alert_thermal_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    byte_t alert_mask_one;
    byte_t alert_mask_two;
    byte_t thermal_pin_config;
    byte_t thermal_timer_limit;
    byte_t alert_pin_config;
    byte_t rdata_next;
    byte_t status_one_flags;
    byte_t status_two_flags;
    byte_t status_two_cond;
    byte_t status_one_view;

    thermal_timer_if tif ();

    // address decode
    wire sel_status_one = reg_addr == `ADDR_STATUS_ONE;
    wire sel_status_two = reg_addr == `ADDR_STATUS_TWO;
    wire sel_mask_one = reg_addr == `ADDR_MASK_ONE;
    wire sel_mask_two = reg_addr == `ADDR_MASK_TWO;
    wire sel_pin_cfg = reg_addr == `ADDR_PIN_CFG;
    wire sel_timer = reg_addr == `ADDR_TIMER;
    wire sel_limit = reg_addr == `ADDR_TIMER_LIMIT;
    wire sel_alert_cfg = reg_addr == `ADDR_ALERT_CFG;

    // read strobes with side effects
    wire rd_status_one = reg_rd && sel_status_one;
    wire rd_status_two = reg_rd && sel_status_two;
    wire rd_timer = reg_rd && sel_timer;

    // mode bits
    wire thermal_pin_select = thermal_pin_config[`BIT_THERMAL_EVENT_PIN_SELECT];
    wire override_enable = thermal_pin_config[`BIT_OVERRIDE_EN];
    wire alert_pin_select = alert_pin_config[`BIT_ALERT_SELECT];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alert_mask_one <= `RESET_BYTE;
            alert_mask_two <= `RESET_BYTE;
            thermal_pin_config <= `RESET_BYTE;
            thermal_timer_limit <= `RESET_TIMER_LIMIT;
            alert_pin_config <= `RESET_BYTE;
        end
        else if (reg_wr)
        begin
            if (sel_mask_one)
                alert_mask_one <= reg_wdata;
            if (sel_mask_two)
                alert_mask_two <= reg_wdata;
            if (sel_pin_cfg)
                thermal_pin_config <= reg_wdata;
            if (sel_limit)
                thermal_timer_limit <= reg_wdata;
            if (sel_alert_cfg)
                alert_pin_config <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // thermal input synchroniser
    logic thermal_event_pin_meta_reg;
    logic thermal_event_pin_sync_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thermal_event_pin_meta_reg <= 1'b1;
            thermal_event_pin_sync_reg <= 1'b1;
        end
        else
        begin
            thermal_event_pin_meta_reg <= thermal_event_pin_n;
            thermal_event_pin_sync_reg <= thermal_event_pin_meta_reg;
        end
    end

    wire thermal_active = thermal_pin_select && !thermal_event_pin_sync_reg;

    ////////////////////////////////////////////////////////////////////
    // thermal timer
    assign tif.active = thermal_active;
    assign tif.rd_clr = rd_timer;
    assign tif.limit = thermal_timer_limit;

    thermal_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer
    (
        .clk(clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////
    // status flags
    wire timer_limit_or_fourth_fan_flag = thermal_pin_select ?
        tif.over : limit_fault_two[`BIT_TIMER_FLAG];

    assign status_two_cond = {limit_fault_two[7:6],
        timer_limit_or_fourth_fan_flag, limit_fault_two[4:0]}
        & `USED_STATUS_TWO;

    status_flag_bank u_status_one
    (
        .clk(clk),
        .rst_n(rst_n),
        .cond(limit_fault_one & `USED_STATUS_ONE & 8'h7F),
        .rd_clr(rd_status_one),
        .flags(status_one_flags)
    );

    status_flag_bank u_status_two
    (
        .clk(clk),
        .rst_n(rst_n),
        .cond(status_two_cond),
        .rd_clr(rd_status_two),
        .flags(status_two_flags)
    );

    wire second_status_summary = |status_two_flags;
    assign status_one_view = {second_status_summary,
        status_one_flags[6:0]};

    ////////////////////////////////////////////////////////////////////
    // read data
    assign rdata_next =
        sel_status_one ? status_one_view :
        sel_status_two ? status_two_flags :
        sel_mask_one ? alert_mask_one :
        sel_mask_two ? alert_mask_two :
        sel_pin_cfg ? thermal_pin_config :
        sel_timer ? tif.value :
        sel_limit ? thermal_timer_limit :
        sel_alert_cfg ? alert_pin_config : `RESET_BYTE;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= `RESET_BYTE;
        else if (reg_rd)
            reg_rdata <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////
    // alert generation
    wire alert_from_one = |(status_one_flags[6:0] & ~alert_mask_one[6:0]);
    wire alert_from_two = !alert_mask_one[`BIT_SUMMARY]
        && |(status_two_flags & ~alert_mask_two);
    wire alert_request = alert_from_one || alert_from_two;
    logic alert_drive_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            alert_drive_reg <= 1'b0;
        else
            alert_drive_reg <= alert_request && alert_pin_select;
    end

    assign alert_pin_o = 1'b0;
    assign alert_pin_oe_n = !alert_drive_reg;

    ////////////////////////////////////////////////////////////////////
    // full speed override
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            full_speed_override <= 3'h0;
        else
            full_speed_override <= {3{override_enable && thermal_active}}
                & fan_running;
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    wire unused_alert_in = alert_pin_i;

    sequence quiet_sources;
        ((status_one_flags[6:0] & ~alert_mask_one[6:0]) == 7'h00)
        && (alert_mask_one[7] || ((status_two_flags & ~alert_mask_two)
        == 8'h00));
    endsequence

    sequence timer_read_armed;
        rd_timer && thermal_active && (thermal_timer_limit == 8'h00);
    endsequence

    cause_sets_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        limit_fault_one[4] |=> status_one_flags[4])
        else $error("status one flag not set by its cause");
    read_clears_gone_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_status_two && status_two_cond == 8'h00
        |=> status_two_flags == 8'h00)
        else $error("status two read left a flag with no cause");
    alert_unmasked_a: assert property (@(posedge clk) disable iff (!rst_n)
        alert_from_one && alert_pin_select |=> !alert_pin_oe_n)
        else $error("alert not driven for unmasked flag");
    masked_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        quiet_sources |=> alert_pin_oe_n)
        else $error("alert driven with all sources masked");
    mask_keeps_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        limit_fault_two[2] && alert_mask_two[2] |=> status_two_flags[2])
        else $error("masked source did not set its flag");
    alert_disabled_a: assert property (@(posedge clk) disable iff (!rst_n)
        !alert_pin_select |=> alert_pin_oe_n)
        else $error("alert driven while pin not selected");
    summary_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_status_one && second_status_summary |=> reg_rdata[7])
        else $error("summary bit not read as one");
    limit_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        thermal_pin_select && tif.over |=> status_two_flags[5])
        else $error("timer over limit did not set flag");
    reflag_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        timer_read_armed ##1 thermal_active |=> status_two_flags[5])
        else $error("limit flag not set again after read");
    override_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        override_enable && thermal_active && fan_running[0]
        |=> full_speed_override[0])
        else $error("override not applied to running fan");
    override_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fan_running[1] |=> !full_speed_override[1])
        else $error("override applied to stopped fan");

    // pin held low over two samples reaches the timer
    sequence pin_held_low;
        !thermal_event_pin_n ##1 !thermal_event_pin_n;
    endsequence

    sequence pin_held_high;
        thermal_event_pin_n ##1 thermal_event_pin_n;
    endsequence

    sequence active_then_zero_limit;
        thermal_active && !rd_timer
        ##1 thermal_pin_select && thermal_timer_limit == 8'h00;
    endsequence

    mask_summary_a: assert property (@(posedge clk) disable iff (!rst_n)
        alert_mask_one[7]
        && ((status_one_flags[6:0] & ~alert_mask_one[6:0]) == 7'h00)
        |=> alert_pin_oe_n)
        else $error("summary mask did not block status two alert");
    timer_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        thermal_pin_select && alert_mask_two[5]
        && status_two_flags == 8'h20
        && ((status_one_flags[6:0] & ~alert_mask_one[6:0]) == 7'h00)
        |=> alert_pin_oe_n)
        else $error("timer limit alert not masked");
    override_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        !thermal_active |=> full_speed_override == 3'h0)
        else $error("override held without thermal input");
    stopped_fan_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fan_running[2] |=> !full_speed_override[2])
        else $error("override applied to stopped fan");
    pin_off_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !thermal_pin_select && !rd_timer |=> $stable(tif.value))
        else $error("timer moved with thermal pin not selected");
    sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
        pin_held_low |=> thermal_active || !thermal_pin_select)
        else $error("thermal input not seen after synchroniser");
    sync_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        pin_held_high |=> !thermal_active)
        else $error("thermal input seen while pin high");
    alert_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        alert_from_two && alert_pin_select |=> !alert_pin_oe_n)
        else $error("alert not driven for status two flag");
    cause_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        limit_fault_two[7] |=> status_two_flags[7])
        else $error("status two flag not set by its cause");
    flag_source_a: assert property (@(posedge clk) disable iff (!rst_n)
        !thermal_pin_select && limit_fault_two[5]
        |=> status_two_flags[5])
        else $error("fourth fan cause did not set bit five");
    first_assert_a: assert property (@(posedge clk) disable iff (!rst_n)
        thermal_active && !rd_timer |=> tif.value != 8'h00)
        else $error("first assertion not shown in timer");
    limit_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        active_then_zero_limit |=> status_two_flags[5])
        else $error("zero limit did not flag first assertion");
    read_clr_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_status_one && ((limit_fault_one & 8'h75) == 8'h00)
        |=> status_one_flags == 8'h00)
        else $error("status one read left a flag with no cause");
endmodule
`default_nettype wire

// ===== alert_thermal_pkg.sv
// types shared by the alert mask and thermal timer block
package alert_thermal_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [22:0] prescale_t;
endpackage

// ===== status_flag_bank.sv
// eight sticky status flags, cleared by a read once the cause is gone
`timescale 1ns/100ps
`default_nettype none
module status_flag_bank
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // causes and read strobe
    input wire alert_thermal_pkg::byte_t cond,
    input wire logic rd_clr,
    // flags
    output alert_thermal_pkg::byte_t flags
);
    import alert_thermal_pkg::*;
    byte_t flag_next;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_flag
            // set wins over the read clear
            assign flag_next[i] = cond[i] | (flags[i] & ~rd_clr);
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    flags[i] <= 1'b0;
                else
                    flags[i] <= flag_next[i];
            end
        end
    endgenerate

    flag_persists_a: assert property (@(posedge clk) disable iff (!rst_n)
        !rd_clr |=> ((flags & $past(flags)) == $past(flags)))
        else $error("sticky flag dropped without a read");
endmodule
`default_nettype wire

// ===== thermal_timer.sv
// cumulative saturating timer of thermal input assertions
`timescale 1ns/100ps
`default_nettype none
`include "alert_thermal_cfg.svh"
module thermal_timer
#(
    parameter int TICK_CYCLES = `TICK_TIME_US * `CLK_FREQ_MHZ
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controller side
    thermal_timer_if.timer tif
);
    import alert_thermal_pkg::*;
    prescale_t prescale_reg;
    byte_t ticks_reg;
    logic seen_reg;
    wire tick_done = prescale_reg == prescale_t'(TICK_CYCLES - 1);
    wire full = ticks_reg == `TIMER_FULL;

    ////////////////////////////////////////////////////////////////////
    // accumulation, paused while negated, cleared by read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prescale_reg <= '0;
            ticks_reg <= `RESET_BYTE;
            seen_reg <= 1'b0;
        end
        else if (tif.rd_clr)
        begin
            prescale_reg <= '0;
            ticks_reg <= `RESET_BYTE;
            seen_reg <= tif.active;
        end
        else if (tif.active && !full)
        begin
            seen_reg <= 1'b1;
            prescale_reg <= tick_done ? '0 : prescale_reg + 23'h1;
            if (tick_done)
                ticks_reg <= ticks_reg + 8'h01;
        end
    end

    // first assertion shows 1, tick count from 45.52 ms on
    assign tif.value = (ticks_reg >= 8'h02) ? ticks_reg : {7'h00, seen_reg};
    assign tif.over = tif.value > tif.limit;

    ////////////////////////////////////////////////////////////////////
    sequence read_while_active;
        tif.rd_clr && tif.active;
    endsequence

    read_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        read_while_active |=> tif.value == 8'h01)
        else $error("read during assertion did not restart at one");
    read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        tif.rd_clr && !tif.active |=> tif.value == 8'h00)
        else $error("timer not cleared by read");
    full_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        full && !tif.rd_clr |=> full)
        else $error("timer left full scale without a read");
    pause_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !tif.active && !tif.rd_clr |=> $stable(ticks_reg))
        else $error("timer moved while input negated");
endmodule
`default_nettype wire

// ===== thermal_timer_if.sv
// carrier between the alert controller and its thermal timer
`timescale 1ns/100ps
`default_nettype none
interface thermal_timer_if;
    import alert_thermal_pkg::*;
    logic active;
    logic rd_clr;
    byte_t limit;
    byte_t value;
    logic over;
    modport timer (input active, input rd_clr, input limit,
                   output value, output over);
    modport ctrl (output active, output rd_clr, output limit,
                  input value, input over);
endinterface
`default_nettype wire
